/* design/serial_pkg.sv */
// shared constants and types for the serial shift unit and its far end
package serial_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] DATA_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS    = 8'h0C;
  localparam logic [7:0] DIR_OFS     = 8'h10;
  // status (and mask) fields
  localparam int ST_START_BIT = 7;
  localparam int ST_OVF_BIT   = 6;
  localparam int ST_CNT_LSB   = 0;
  localparam int CNT_W        = 4;
  // control fields
  localparam int CR_WM_LSB  = 4;
  localparam int CR_CS1_BIT = 3;
  localparam int CR_CS0_BIT = 2;
  localparam int CR_CLK_BIT = 1;
  localparam int CR_TC_BIT  = 0;
  // pin direction fields
  localparam int DIR_CLK_BIT  = 0;
  localparam int DIR_DATA_BIT = 1;
  // reset values
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'h00;
  // shift geometry
  localparam int BYTE_W = 8;
  // link timing for the far end clock generator
  localparam int LINK_PERIOD_NS = 400;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} wire_mode_t;
  typedef enum logic [1:0] {ROLE_M3, ROLE_S3, ROLE_M2} far_role_t;
endpackage

/* design/serial_link_if.sv */
// serial link wiring between the shift unit and its far end
`timescale 1ns/1ns
interface serial_link_if;
  logic dev_ck_o;
  logic dev_ck_oe;
  logic dev_do_o;
  logic dev_do_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic far_ck_o;
  logic far_ck_oe;
  logic far_do_o;
  logic far_do_oe;
  logic far_sda_o;
  logic far_sda_oe;
  logic ck_line;
  logic sda_line;
  logic dev_di_line;
  logic far_di_line;

  // clock and sda are wired-and with pull-up; undriven data reads high
  assign ck_line     = (dev_ck_oe ? dev_ck_o : 1'b1) & (far_ck_oe ? far_ck_o : 1'b1);
  assign sda_line    = (dev_sda_oe ? dev_sda_o : 1'b1) & (far_sda_oe ? far_sda_o : 1'b1);
  assign dev_di_line = far_do_oe ? far_do_o : 1'b1;
  assign far_di_line = dev_do_oe ? dev_do_o : 1'b1;

  modport dev (
    output dev_ck_o, dev_ck_oe, dev_do_o, dev_do_oe, dev_sda_o, dev_sda_oe,
    input  ck_line, sda_line, dev_di_line
  );
  modport far (
    output far_ck_o, far_ck_oe, far_do_o, far_do_oe, far_sda_o, far_sda_oe,
    input  ck_line, sda_line, far_di_line
  );
endinterface

/* design/serial_shift_interface.sv */
// serial shift unit: apb registers, shift register, edge counter, pin control
// Behaviour
// - status write loads counter, clears overflow when bit 6 is set
// - control selects mode, edge, count source, toggle
// - software master strobes sixteen times per byte
// - alternating strobe writes reach quarter clock rate
// - msb shifted out first, received byte readable
// - slave drives data, clock pin is input
// - slave sets overflow flag after full byte
// - two-wire bus without slew or filtering
// - master clocks in software, slave holds clock
// - two-wire shifting configured on positive edge
// - slave stretches clock, master checks release
// - counter counts both edges, sixteen overflow
// - sample first edge, change output opposite
// - detect start, hold clock after falling edge
// - overflow holds clock low until cleared
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module serial_shift_interface (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic            pready,
  output logic [31:0]     prdata,
  output logic            pslverr,
  // serial pins
  serial_link_if.dev      link,
  // interrupt
  output logic            irq
);
  import serial_pkg::*;

  logic [2:0]       ck_s_q;
  logic [2:0]       di_s_q;
  logic [2:0]       sda_s_q;
  logic [BYTE_W-1:0] sr_q;
  logic [CNT_W-1:0] cnt_q;
  logic             ovf_q;
  logic             start_q;
  logic             hold_start_q;
  logic             do_q;
  logic             clk_out_q;
  wire_mode_t       mode_q;
  logic             cs1_q;
  logic             cs0_q;
  logic             clk_cfg_q;
  logic [7:0]       mask_q;
  logic [7:0]       dir_q;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             irq_q;
  logic             ck_o_q;
  logic             ck_oe_q;
  logic             do_o_q;
  logic             do_oe_q;
  logic             sda_oe_q;

  logic wr_en, wr_data, wr_status, wr_control;
  logic sw_clk, sw_tc, ck_rise, ck_fall, two_wire;
  logic shift_ev, change_ev, count_ev, start_det, hold, cs1_now, cs0_now, clk_now;

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign link.dev_ck_o   = ck_o_q;
  assign link.dev_ck_oe  = ck_oe_q;
  assign link.dev_do_o   = do_o_q;
  assign link.dev_do_oe  = do_oe_q;
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe_q;

  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  assign two_wire   = (mode_q == WM_TWO) || (mode_q == WM_TWO_HOLD);
  assign wr_en      = psel && penable && pwrite && pready_q;
  assign wr_data    = wr_en && (paddr == DATA_OFS);
  assign wr_status  = wr_en && (paddr == STATUS_OFS);
  assign wr_control = wr_en && (paddr == CONTROL_OFS);
  // strobes act at the write edge, so one write per toggle gives fck/4 at best
  assign sw_clk  = wr_control && pwdata[CR_CLK_BIT] && !pwdata[CR_CS1_BIT];
  assign sw_tc   = wr_control && pwdata[CR_TC_BIT];
  assign ck_rise = ck_s_q[1] && !ck_s_q[2];
  assign ck_fall = !ck_s_q[1] && ck_s_q[2];

  // external clock: sample on the selected edge, change output on the other
  // a control write acts with the settings it carries, so its own strobe counts
  assign cs1_now   = wr_control ? pwdata[CR_CS1_BIT] : cs1_q;
  assign cs0_now   = wr_control ? pwdata[CR_CS0_BIT] : cs0_q;
  assign clk_now   = wr_control ? pwdata[CR_CLK_BIT] : clk_cfg_q;
  assign shift_ev  = cs1_now ? (cs0_now ? ck_fall : ck_rise) : sw_clk;
  assign change_ev = cs1_now ? (cs0_now ? ck_rise : ck_fall) : 1'b1;
  // with an external clock the counter sees both pin edges unless the toggle strobe is chosen; otherwise it counts the software strobe
  assign count_ev  = cs1_now ? (clk_now ? sw_tc : (ck_rise || ck_fall)) : sw_clk;
  // sda falls while scl stays high; sda and scl are taken from the same synchroniser stages
  assign start_det = two_wire && ck_s_q[1] && ck_s_q[2] && sda_s_q[2] && !sda_s_q[1];
  assign hold      = hold_start_q || ((mode_q == WM_TWO_HOLD) && ovf_q);

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk) begin
    if (srst) begin
      ck_s_q  <= 3'h7;
      di_s_q  <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      ck_s_q  <= {ck_s_q[1:0], link.ck_line};
      di_s_q  <= {di_s_q[1:0], link.dev_di_line};
      sda_s_q <= {sda_s_q[1:0], link.sda_line};
    end
  end

  // apb slave: zero wait states, error on unmapped offsets
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && !penable && !pready_q;
      pslverr_q <= 1'b0;
      if (psel && !penable) begin
        prdata_q <= 32'h00000000;
        if (paddr == DATA_OFS) begin
          prdata_q <= word8(sr_q);
        end else if (paddr == STATUS_OFS) begin
          prdata_q <= word8({start_q, ovf_q, 2'b00, cnt_q});
        end else if (paddr == CONTROL_OFS) begin
          prdata_q <= word8({2'b00, mode_q, cs1_q, cs0_q, clk_cfg_q, 1'b0});
        end else if (paddr == MASK_OFS) begin
          prdata_q <= word8(mask_q);
        end else if (paddr == DIR_OFS) begin
          prdata_q <= word8(dir_q);
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q    <= wire_mode_t'(CONTROL_RST[CR_WM_LSB +: 2]);
      cs1_q     <= CONTROL_RST[CR_CS1_BIT];
      cs0_q     <= CONTROL_RST[CR_CS0_BIT];
      clk_cfg_q <= CONTROL_RST[CR_CLK_BIT];
      mask_q    <= MASK_RST;
      dir_q     <= DIR_RST;
    end else begin
      if (wr_control) begin
        mode_q    <= wire_mode_t'(pwdata[CR_WM_LSB +: 2]);
        cs1_q     <= pwdata[CR_CS1_BIT];
        cs0_q     <= pwdata[CR_CS0_BIT];
        clk_cfg_q <= pwdata[CR_CLK_BIT];
      end
      if (wr_en && (paddr == MASK_OFS)) begin
        mask_q <= pwdata[7:0];
      end
      if (wr_en && (paddr == DIR_OFS)) begin
        dir_q <= pwdata[7:0];
      end
    end
  end

  // shift register and output latch
  always_ff @(posedge clk) begin
    if (srst) begin
      sr_q <= DATA_RST;
      do_q <= DATA_RST[BYTE_W-1];
    end else if (wr_data) begin
      sr_q <= pwdata[BYTE_W-1:0];
      do_q <= pwdata[BYTE_W-1];
    end else begin
      if (shift_ev) begin
        sr_q <= {sr_q[BYTE_W-2:0], (two_wire ? sda_s_q[1] : di_s_q[1])};
      end
      if (change_ev && !shift_ev) begin
        do_q <= sr_q[BYTE_W-1];
      end
    end
  end

  // edge counter and overflow; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (wr_status) begin
        cnt_q <= pwdata[ST_CNT_LSB +: CNT_W];
      end else if (count_ev) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (count_ev && (cnt_q == 4'hF)) begin
        ovf_q <= 1'b1;
      end else if (wr_status && pwdata[ST_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // start condition flag and clock hold after it
  always_ff @(posedge clk) begin
    if (srst) begin
      start_q      <= 1'b0;
      hold_start_q <= 1'b0;
    end else begin
      if (start_det) begin
        start_q <= 1'b1;
      end else if (wr_status && pwdata[ST_START_BIT]) begin
        start_q <= 1'b0;
      end
      if (!start_q || !two_wire) begin
        hold_start_q <= 1'b0;
      end else if (ck_fall) begin
        hold_start_q <= 1'b1;
      end
    end
  end

  // clock pin toggle and registered pin drivers
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_out_q <= 1'b0;
      ck_o_q    <= 1'b0;
      ck_oe_q   <= 1'b0;
      do_o_q    <= 1'b1;
      do_oe_q   <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else begin
      if (sw_tc) begin
        clk_out_q <= !clk_out_q;
      end
      ck_o_q   <= 1'b0;
      ck_oe_q  <= 1'b0;
      do_o_q   <= do_q;
      do_oe_q  <= 1'b0;
      sda_oe_q <= 1'b0;
      if (mode_q == WM_THREE) begin
        // slave leaves the clock pin as input and drives data only
        ck_o_q  <= clk_out_q;
        ck_oe_q <= dir_q[DIR_CLK_BIT];
        do_oe_q <= dir_q[DIR_DATA_BIT];
      end else if (two_wire) begin
        // open drain, no edge shaping: pull low or release
        ck_oe_q  <= (dir_q[DIR_CLK_BIT] && !clk_out_q) || hold;
        sda_oe_q <= dir_q[DIR_DATA_BIT] && !do_q;
      end
    end
  end

  // level interrupt from masked sticky flags
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (start_q && mask_q[ST_START_BIT]) || (ovf_q && mask_q[ST_OVF_BIT]);
    end
  end

endmodule // serial_shift_interface

/* design/serial_far_end.sv */
// far end of the serial link: three-wire master or slave, two-wire master
`timescale 1ns/1ns
module serial_far_end #(
  parameter int HALF_CYC = serial_pkg::LINK_HALF_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // serial pins
  serial_link_if.far                link,
  // user side
  input  wire serial_pkg::far_role_t role,
  input  wire logic                 start,
  input  wire logic [7:0]           tx_byte,
  output logic                      busy,
  output logic                      done,
  output logic [7:0]                rx_byte,
  output logic                      ack_bit
);
  import serial_pkg::*;

  typedef enum {F_IDLE, F_M3_LOW, F_M3_HIGH, F_S3, F_M2_START, F_M2_LOW, F_M2_WAIT,
                F_M2_HIGH, F_M2_STOP_LOW, F_M2_STOP_WAIT, F_M2_STOP_HIGH} far_state_t;

  far_state_t state_q;
  logic [2:0] ck_s_q;
  logic [2:0] di_s_q;
  logic [7:0] sr_q;
  logic [3:0] bit_q;
  logic [7:0] tmr_q;
  logic       ck_o_q;
  logic       ck_oe_q;
  logic       do_q;
  logic       do_oe_q;
  logic       sda_oe_q;
  logic       busy_q;
  logic       done_q;
  logic [7:0] rx_q;
  logic       ack_q;
  logic [2:0] sda_s_q;

  localparam logic [7:0] HALF = 8'(HALF_CYC);
  wire tdone = (tmr_q == 8'h00);

  assign link.far_ck_o   = ck_o_q;
  assign link.far_ck_oe  = ck_oe_q;
  assign link.far_do_o   = do_q;
  assign link.far_do_oe  = do_oe_q;
  assign link.far_sda_o  = 1'b0;
  assign link.far_sda_oe = sda_oe_q;
  assign busy    = busy_q;
  assign done    = done_q;
  assign rx_byte = rx_q;
  assign ack_bit = ack_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ck_s_q  <= 3'h7;
      di_s_q  <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      ck_s_q  <= {ck_s_q[1:0], link.ck_line};
      di_s_q  <= {di_s_q[1:0], link.far_di_line};
      sda_s_q <= {sda_s_q[1:0], link.sda_line};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= F_IDLE;
      sr_q <= 8'h00; bit_q <= 4'h0; tmr_q <= 8'h00;
      ck_o_q <= 1'b0; ck_oe_q <= 1'b0; do_q <= 1'b1; do_oe_q <= 1'b0; sda_oe_q <= 1'b0;
      busy_q <= 1'b0; done_q <= 1'b0; rx_q <= 8'h00; ack_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (!tdone) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        F_IDLE: begin
          if (start) begin
            sr_q <= tx_byte;
            bit_q <= 4'h0;
            busy_q <= 1'b1;
            tmr_q <= HALF;
            if (role == ROLE_M3) begin
              ck_o_q <= 1'b0; ck_oe_q <= 1'b1; do_oe_q <= 1'b1; do_q <= tx_byte[7];
              state_q <= F_M3_LOW;
            end else if (role == ROLE_S3) begin
              // let go of a clock parked low by an earlier master frame
              ck_oe_q <= 1'b0;
              do_oe_q <= 1'b1; do_q <= tx_byte[7];
              state_q <= F_S3;
            end else begin
              sda_oe_q <= 1'b1;  // start: sda low while scl high
              state_q <= F_M2_START;
            end
          end
        end
        F_M3_LOW: if (tdone) begin
          ck_o_q <= 1'b1; tmr_q <= HALF; state_q <= F_M3_HIGH;
        end
        F_M3_HIGH: if (tdone) begin
          // sample late in the high phase, after the synchroniser delay
          sr_q <= {sr_q[6:0], di_s_q[1]};
          do_q <= sr_q[6];
          ck_o_q <= 1'b0;
          tmr_q <= HALF;
          if (bit_q == 4'h7) begin  // sixteen edges make one byte
            rx_q <= {sr_q[6:0], di_s_q[1]}; done_q <= 1'b1; busy_q <= 1'b0;
            state_q <= F_IDLE;
          end else begin
            bit_q <= bit_q + 4'h1; state_q <= F_M3_LOW;
          end
        end
        F_S3: begin
          if (ck_s_q[1] && !ck_s_q[2]) begin
            sr_q <= {sr_q[6:0], di_s_q[1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              rx_q <= {sr_q[6:0], di_s_q[1]}; done_q <= 1'b1; busy_q <= 1'b0;
              do_oe_q <= 1'b0; state_q <= F_IDLE;
            end
          end else if (!ck_s_q[1] && ck_s_q[2]) begin
            do_q <= sr_q[7];
          end
        end
        F_M2_START: if (tdone) begin
          // master makes every falling clock edge itself; rising edges wait on the released line
          ck_oe_q <= 1'b1; sda_oe_q <= !sr_q[7]; tmr_q <= HALF; state_q <= F_M2_LOW;
        end
        F_M2_LOW: if (tdone) begin
          ck_oe_q <= 1'b0; state_q <= F_M2_WAIT;
        end
        F_M2_WAIT: if (ck_s_q[1]) begin  // slave may stretch scl low
          tmr_q <= HALF; state_q <= F_M2_HIGH;
        end
        F_M2_HIGH: if (tdone) begin
          ck_oe_q <= 1'b1;
          tmr_q <= HALF;
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h8) begin
            ack_q <= sda_s_q[1]; sda_oe_q <= 1'b1; state_q <= F_M2_STOP_LOW;
          end else begin
            sr_q <= {sr_q[6:0], 1'b1};
            sda_oe_q <= (bit_q == 4'h7) ? 1'b0 : !sr_q[6];  // release for ack
            state_q <= F_M2_LOW;
          end
        end
        F_M2_STOP_LOW: if (tdone) begin
          ck_oe_q <= 1'b0; state_q <= F_M2_STOP_WAIT;
        end
        F_M2_STOP_WAIT: if (ck_s_q[1]) begin
          tmr_q <= HALF; state_q <= F_M2_STOP_HIGH;
        end
        F_M2_STOP_HIGH: if (tdone) begin
          sda_oe_q <= 1'b0; done_q <= 1'b1; busy_q <= 1'b0; state_q <= F_IDLE;
        end
        default: state_q <= F_IDLE;
      endcase
    end
  end

endmodule // serial_far_end

/* bench/serial_shift_interface_checker.sv */
// link assertions between the shift unit and its far end
`timescale 1ns/1ns
module serial_shift_interface_checker (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // device end pins
  input wire logic dev_ck_o,
  input wire logic dev_ck_oe,
  input wire logic dev_do_o,
  input wire logic dev_do_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // far end pins and shared clock line
  input wire logic far_ck_o,
  input wire logic far_ck_oe,
  input wire logic far_do_oe,
  input wire logic far_sda_o,
  input wire logic far_sda_oe,
  input wire logic ck_line
);
  // far end is not pulling the clock line low
  wire logic far_rel = !(far_ck_oe && !far_ck_o);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  dev_sda_open_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives sda high");
  far_sda_open_a: assert property (far_sda_oe |-> !far_sda_o)
    else $error("far end drives sda high");
  ck_toggle_rate_a: assert property ($changed(dev_ck_o) |=> $stable(dev_ck_o))
    else $error("clock output toggled in two cycles running");
  ck_high_dwell_a: assert property ($rose(ck_line) |=> ck_line)
    else $error("clock line high for a single cycle");
  ck_low_dwell_a: assert property ($fell(ck_line) |=> !ck_line)
    else $error("clock line low for a single cycle");
  // a stretched clock must be waited out, never pulled again
  stretch_wait_a: assert property (far_rel && !ck_line |=> far_rel)
    else $error("far end pulled the clock before it rose");
  dev_reset_quiet_a: assert property ($fell(srst) |->
    !dev_ck_oe && !dev_do_oe && !dev_sda_oe && dev_do_o)
    else $error("device pins driven after reset");
  far_reset_quiet_a: assert property ($fell(srst) |->
    !far_ck_oe && !far_do_oe && !far_sda_oe)
    else $error("far end pins driven after reset");
endmodule // serial_shift_interface_checker

/* bench/serial_shift_interface_tb.sv */
// self-checking bench: shift unit facing its far end over the link
`timescale 1ns/1ns
module serial_shift_interface_tb;
  import serial_pkg::*;
  logic        clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  far_role_t   role;
  logic        start;
  logic [7:0]  tx_byte;
  logic        done;
  logic [7:0]  rx_byte;
  logic        ack_bit;
  logic [7:0]  d, f;
  logic [31:0] r;
  logic        e;
  int          fails, comparisons, cycles, done_cnt, seed, i, t0, c0;

  serial_link_if serial_link_if_inst ();
  serial_shift_interface serial_shift_interface_inst (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link(serial_link_if_inst.dev), .irq(irq));
  serial_far_end #(.HALF_CYC(4)) serial_far_end_inst (.clk(clk), .srst(srst),
    .link(serial_link_if_inst.far), .role(role), .start(start), .tx_byte(tx_byte),
    .busy(), .done(done), .rx_byte(rx_byte), .ack_bit(ack_bit));
  serial_shift_interface_checker serial_shift_interface_checker_inst (.clk(clk), .srst(srst),
    .dev_ck_o(serial_link_if_inst.dev_ck_o), .dev_ck_oe(serial_link_if_inst.dev_ck_oe),
    .dev_do_o(serial_link_if_inst.dev_do_o), .dev_do_oe(serial_link_if_inst.dev_do_oe),
    .dev_sda_o(serial_link_if_inst.dev_sda_o), .dev_sda_oe(serial_link_if_inst.dev_sda_oe),
    .far_ck_o(serial_link_if_inst.far_ck_o), .far_ck_oe(serial_link_if_inst.far_ck_oe),
    .far_do_oe(serial_link_if_inst.far_do_oe), .far_sda_o(serial_link_if_inst.far_sda_o),
    .far_sda_oe(serial_link_if_inst.far_sda_oe), .ck_line(serial_link_if_inst.ck_line));

  always #25 clk = ~clk;

  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // done is a one-cycle pulse, so it is counted here rather than polled
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk8(input string what, input logic [7:0] x, input logic [7:0] got);
    comparisons++;
    if (got !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", what, x, got);
    end
  endtask

  task automatic chk1(input string what, input logic x, input logic got);
    comparisons++;
    if (got !== x) begin
      fails++;
      $display("BAD %s exp %b got %b", what, x, got);
    end
  endtask

  // hold keeps psel up so the next setup follows at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input bit hold, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    if (!hold) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    apb(1'b1, a, {24'h000000, x}, 1'b0, r, e);
  endtask

  task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0, 1'b0, r, e);
    chk8(what, x, r[7:0]);
  endtask

  task automatic poll(input int b);
    apb(1'b0, STATUS_OFS, 32'h0, 1'b0, r, e);
    while (r[b] !== 1'b1) begin
      apb(1'b0, STATUS_OFS, 32'h0, 1'b0, r, e);
    end
  endtask

  task automatic far_go(input far_role_t ro, input logic [7:0] x);
    role <= ro;
    tx_byte <= x;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask

  task automatic wait_far(input int c);
    while (done_cnt == c) begin
      @(posedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, start} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    role = ROLE_M3;
    tx_byte = 8'h00;
    {fails, comparisons, cycles, done_cnt} = {4{32'h0}};
    seed = 34629;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    reg_chk("data reset", DATA_OFS, DATA_RST);
    reg_chk("control reset", CONTROL_OFS, CONTROL_RST);
    reg_chk("mask reset", MASK_OFS, MASK_RST);
    reg_chk("dir reset", DIR_OFS, DIR_RST);
    apb(1'b1, 8'h14, 32'hFF, 1'b0, r, e);
    chk1("unmapped write err", 1'b1, e);
    apb(1'b0, 8'h14, 32'h0, 1'b0, r, e);
    chk1("unmapped read err", 1'b1, e);
    chk8("unmapped read data", 8'h00, r[7:0]);
    wr(CONTROL_OFS, 8'h3E);
    reg_chk("control readback", CONTROL_OFS, 8'h3E);
    // device as three-wire slave, far end clocks
    wr(CONTROL_OFS, 8'h18);
    wr(DIR_OFS, 8'h02);
    // first frame only parks the far clock low; its pull-up to low edge is not data
    c0 = done_cnt;
    far_go(ROLE_M3, 8'h00);
    wait_far(c0);
    for (i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($random(seed));
      f = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
      wr(DATA_OFS, d);
      wr(STATUS_OFS, 8'h40);
      reg_chk("status cleared", STATUS_OFS, 8'h00);
      c0 = done_cnt;
      far_go(ROLE_M3, f);
      wait_far(c0);
      chk8("far rx slave mode", d, rx_byte);
      poll(ST_OVF_BIT);
      reg_chk("slave status", STATUS_OFS, 8'h40);
      reg_chk("slave rx", DATA_OFS, f);
      chk1("masked irq", 1'b0, irq);
    end
    // back-to-back strobe writes: 16 writes of two cycles plus idle
    wr(DIR_OFS, 8'h03);
    wr(STATUS_OFS, 8'h40);
    t0 = cycles;
    for (i = 0; i < 16; i++) apb(1'b1, CONTROL_OFS, i[0] ? 32'h13 : 32'h11, i != 15, r, e);
    chk8("fast span", 8'h21, 8'(cycles - t0));
    reg_chk("fast count", STATUS_OFS, 8'h08);
    // device as three-wire master, software strobes
    d = 8'($random(seed));
    f = 8'($random(seed));
    wr(DATA_OFS, d);
    wr(STATUS_OFS, 8'h40);
    c0 = done_cnt;
    far_go(ROLE_S3, f);
    for (i = 0; i < 16; i++) begin
      wr(CONTROL_OFS, 8'h1B);
      repeat (4) @(posedge clk);
    end
    wait_far(c0);
    chk8("far rx master mode", d, rx_byte);
    reg_chk("master status", STATUS_OFS, 8'h40);
    reg_chk("master rx", DATA_OFS, f);
    // two-wire slave with overflow hold, far end as bus master
    wr(DIR_OFS, 8'h00);
    wr(STATUS_OFS, 8'hC0);
    wr(MASK_OFS, 8'hC0);
    reg_chk("mask readback", MASK_OFS, 8'hC0);
    wr(CONTROL_OFS, 8'h38);
    d = 8'($random(seed));
    c0 = done_cnt;
    far_go(ROLE_M2, d);
    poll(ST_START_BIT);
    chk1("start irq", 1'b1, irq);
    repeat (12) @(posedge clk);
    chk1("far released", 1'b0,
         serial_link_if_inst.far_ck_oe & ~serial_link_if_inst.far_ck_o);
    chk1("start hold", 1'b0, serial_link_if_inst.ck_line);
    wr(STATUS_OFS, 8'h80);
    poll(ST_OVF_BIT);
    repeat (12) @(posedge clk);
    chk1("overflow hold", 1'b0, serial_link_if_inst.ck_line);
    chk1("overflow irq", 1'b1, irq);
    reg_chk("address rx", DATA_OFS, d);
    reg_chk("two-wire status", STATUS_OFS, 8'h40);
    wr(STATUS_OFS, 8'h40);
    wait_far(c0);
    chk1("ack released", 1'b1, ack_bit);
    chk1("irq cleared", 1'b0, irq);
    close_out();
  end
endmodule // serial_shift_interface_tb
